// file: design/mps_sequencer.sv
// module power state sequencer with apb control registers
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps

// What this block does
// - power self first, then raise carrier enable
// - release system reset after carrier enable
// - shutdown: assert reset, then drop carrier enable
// - carrier drops supplies, then module powers off
// - three states off, on, sleep; off default
// - off to on on button rise, power good
// - optional power on from charger present
// - off only from on; 7 s button hold
// - software shutdown only in on, software running
// - unsafe temperature shuts down from any state
// - brown-out below 5V shuts down anywhere
// - sleep only from on by software command
// - outputs hold their level during sleep
// - wake event returns to on without reboot
// - timer programmed at sleep entry wakes on expiry
// - hot or cold limit crossing wakes sleep
// - low input voltage can wake sleep
// - usb, sd, wlan, bt wakes individually enabled
// - connector wakes use fixed wake indices
module mps_sequencer
  import mps_pkg::*;
#(
  parameter longint BTN_HOLD_CYC = MPS_BTN_HOLD_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // apb slave
  input wire mps_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // carrier side pins
  input wire logic power_button_in_n,
  input wire logic input_power_bad_n,
  input wire logic charger_present_n,
  input wire logic recovery_strap_in_n,
  input wire logic pcie_wake_request_n,
  input wire logic battery_low_in_n,
  input wire logic sleep_request_n,
  output logic carrier_power_enable_out,
  output logic system_reset_out_n,
  // on-module sources
  input wire mps_env_t env,
  input wire logic usb_vbus_detect,
  input wire logic sd_card_detect,
  input wire logic wlan_wake,
  input wire logic bt_wake,
  input wire logic self_power_good,
  // power state status
  output logic self_power_enable,
  output mps_state_t power_state
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  mps_seq_t seq;
  logic btn_prev;
  logic [39:0] hold_cnt;
  logic [7:0] step_cnt;
  logic [31:0] timer_load;
  logic [31:0] timer_cnt;
  logic timer_run;
  logic sw_running;
  logic charger_on_en;
  logic [MPS_WAKE_W-1:0] wake_en;
  logic [MPS_WAKE_W-1:0] wake_raw;
  logic [MPS_WAKE_W-1:0] wake_st;
  logic [MPS_WAKE_W-1:0] wake_clr;
  logic wake_hit;
  logic btn_rise;
  logic power_ok;
  logic forced_off;
  logic off_event;
  logic on_event;
  logic step_done;
  logic wr_en;
  logic rd_en;
  logic cmd_shutdown;
  logic cmd_sleep;
  logic [31:0] next_prdata;
  logic addr_ok;

  function automatic logic [1:0] word_sel(input logic [11:0] a,
                                          input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    word_sel = d[3:2];
  endfunction : word_sel

  function automatic logic in_bank(input logic [11:0] a,
                                   input logic [11:0] base);
    in_bank = (a >= base) && (a < base + 12'h010);
  endfunction : in_bank

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; single-cycle access, no wait states

  assign pready = 1'b1;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && !apb_req.pwrite;
  assign addr_ok = (apb_req.paddr == MPS_REG_CTRL) ||
                   (apb_req.paddr == MPS_REG_STATUS) ||
                   (apb_req.paddr == MPS_REG_TIMER) ||
                   in_bank(apb_req.paddr, MPS_REG_WAKE_EN0) ||
                   in_bank(apb_req.paddr, MPS_REG_WAKE_ST0);
  assign pslverr = apb_req.psel && apb_req.penable &&
                   (!addr_ok || apb_req.paddr[1:0] != 2'b00);
  assign cmd_shutdown = wr_en && apb_req.paddr == MPS_REG_CTRL &&
                        apb_req.pwdata[MPS_CTRL_SHUTDOWN];
  assign cmd_sleep = wr_en && apb_req.paddr == MPS_REG_CTRL &&
                     apb_req.pwdata[MPS_CTRL_SLEEP];

  always_comb begin
    next_prdata = MPS_ZERO;
    if (apb_req.paddr == MPS_REG_CTRL) begin
      next_prdata[MPS_CTRL_SW_UP] = sw_running;
      next_prdata[MPS_CTRL_CHG_ON] = charger_on_en;
    end else if (apb_req.paddr == MPS_REG_STATUS) begin
      next_prdata = {20'h00000, 1'b0, timer_run, system_reset_out_n,
                     carrier_power_enable_out, 1'b0, seq, 2'b00,
                     power_state};
    end else if (apb_req.paddr == MPS_REG_TIMER) begin
      next_prdata = timer_cnt;
    end else if (in_bank(apb_req.paddr, MPS_REG_WAKE_EN0)) begin
      next_prdata = wake_en[word_sel(apb_req.paddr, MPS_REG_WAKE_EN0)*32
                            +: 32];
    end else if (in_bank(apb_req.paddr, MPS_REG_WAKE_ST0)) begin
      next_prdata = wake_st[word_sel(apb_req.paddr, MPS_REG_WAKE_ST0)*32
                            +: 32];
    end
  end

  // read data registered in setup so it is stable in the access phase
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !apb_req.penable) begin
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software control registers

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sw_running <= 1'b0;
      charger_on_en <= 1'b0;
      timer_load <= 32'h0000_0000;
      wake_en <= '0;
    end else begin
      if (wr_en && apb_req.paddr == MPS_REG_CTRL) begin
        sw_running <= apb_req.pwdata[MPS_CTRL_SW_UP];
        charger_on_en <= apb_req.pwdata[MPS_CTRL_CHG_ON];
      end else if (power_state == MPS_OFF) begin
        sw_running <= 1'b0; // software must re-announce after boot
      end
      if (wr_en && apb_req.paddr == MPS_REG_TIMER) begin
        timer_load <= apb_req.pwdata;
      end
      if (wr_en && in_bank(apb_req.paddr, MPS_REG_WAKE_EN0)) begin
        wake_en[word_sel(apb_req.paddr, MPS_REG_WAKE_EN0)*32 +: 32]
          <= apb_req.pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake sources mapped to their indices

  always_comb begin
    wake_raw = '0;
    wake_raw[MPS_WAKE_PCIE] = !pcie_wake_request_n;
    wake_raw[MPS_WAKE_PWRBTN] = !power_button_in_n;
    wake_raw[MPS_WAKE_RECOVERY] = !recovery_strap_in_n;
    wake_raw[MPS_WAKE_SLEEP] = !sleep_request_n;
    wake_raw[MPS_WAKE_BATTERY_LOW_IN_N] = !battery_low_in_n;
    wake_raw[MPS_WAKE_USB_VBUS] = usb_vbus_detect;
    wake_raw[MPS_WAKE_WIFI] = wlan_wake;
    wake_raw[MPS_WAKE_BT] = bt_wake;
    wake_raw[MPS_WAKE_SD_CD] = sd_card_detect;
    wake_raw[MPS_WAKE_RTC] = timer_run && timer_cnt == 32'h0000_0001;
    wake_raw[MPS_WAKE_THERMAL] = env.temp_hot || env.temp_cold;
    wake_raw[MPS_WAKE_LOW_VIN] = env.low_vin;
  end

  assign wake_hit = |(wake_raw & wake_en);

  always_comb begin
    wake_clr = '0;
    if (wr_en && in_bank(apb_req.paddr, MPS_REG_WAKE_ST0)) begin
      wake_clr[word_sel(apb_req.paddr, MPS_REG_WAKE_ST0)*32 +: 32] =
        apb_req.pwdata;
    end
  end

  // sticky wake status, cleared by writing one; a new event wins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wake_st <= '0;
    end else if (power_state == MPS_SLEEP) begin
      wake_st <= (wake_st & ~wake_clr) | (wake_raw & wake_en);
    end else begin
      wake_st <= wake_st & ~wake_clr;
    end
  end

  // always-on timer, loaded at sleep entry
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      timer_cnt <= 32'h0000_0000;
      timer_run <= 1'b0;
    end else if (cmd_sleep && power_state == MPS_ON) begin
      timer_cnt <= timer_load;
      timer_run <= timer_load != 32'h0000_0000;
    end else if (power_state != MPS_SLEEP) begin
      timer_run <= 1'b0;
    end else if (timer_run) begin
      timer_cnt <= timer_cnt - 32'h0000_0001;
      timer_run <= timer_cnt != 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events

  assign btn_rise = power_button_in_n && !btn_prev;
  assign power_ok = input_power_bad_n;
  assign forced_off = env.thermal_unsafe || env.brown_out;
  assign on_event = power_ok && (btn_rise ||
                    (charger_on_en && !charger_present_n));
  assign off_event = (power_state == MPS_ON && seq == MPS_SEQ_RUN &&
                      (hold_cnt >= 40'(BTN_HOLD_CYC) ||
                       (cmd_shutdown && sw_running)));
  assign step_done = step_cnt == 8'(MPS_STEP_CYC - 1);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      btn_prev <= 1'b1;
      hold_cnt <= 40'h00_0000_0000;
    end else begin
      btn_prev <= power_button_in_n;
      if (power_button_in_n || power_state != MPS_ON) begin
        hold_cnt <= 40'h00_0000_0000;
      end else if (hold_cnt < 40'(BTN_HOLD_CYC)) begin
        hold_cnt <= hold_cnt + 40'h00_0000_0001;
      end
    end
  end

  // spacing between sequencing steps
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      step_cnt <= 8'h00;
    end else if (seq == MPS_SEQ_IDLE || seq == MPS_SEQ_RUN || step_done) begin
      step_cnt <= 8'h00;
    end else begin
      step_cnt <= step_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state and sequencing

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_state <= MPS_OFF;
      seq <= MPS_SEQ_IDLE;
    end else if (forced_off && seq != MPS_SEQ_IDLE &&
                 seq != MPS_SEQ_RESET && seq != MPS_SEQ_DROP &&
                 seq != MPS_SEQ_SELFOFF) begin
      seq <= MPS_SEQ_RESET;
      // leave sleep first, so off is only ever entered from on
      if (power_state == MPS_SLEEP) begin
        power_state <= MPS_ON;
      end
    end else begin
      case (seq)
        MPS_SEQ_IDLE: begin
          if (on_event && !forced_off) begin
            seq <= MPS_SEQ_SELF;
          end
        end
        MPS_SEQ_SELF: begin
          if (self_power_good && step_done) begin
            seq <= MPS_SEQ_CARRIER;
          end
        end
        MPS_SEQ_CARRIER: begin
          if (step_done) begin
            seq <= MPS_SEQ_RUN;
            power_state <= MPS_ON;
          end
        end
        MPS_SEQ_RUN: begin
          if (power_state == MPS_SLEEP) begin
            if (wake_hit) begin
              power_state <= MPS_ON;
            end
          end else if (off_event) begin
            seq <= MPS_SEQ_RESET;
          end else if (cmd_sleep) begin
            power_state <= MPS_SLEEP;
          end
        end
        MPS_SEQ_RESET: begin
          if (step_done) begin
            seq <= MPS_SEQ_DROP;
          end
        end
        MPS_SEQ_DROP: begin
          if (step_done) begin
            seq <= MPS_SEQ_SELFOFF;
          end
        end
        MPS_SEQ_SELFOFF: begin
          if (step_done) begin
            seq <= MPS_SEQ_IDLE;
            power_state <= MPS_OFF;
          end
        end
        default: begin
          seq <= MPS_SEQ_IDLE;
          power_state <= MPS_OFF;
        end
      endcase
    end
  end

  // outputs follow the phase only; sleep changes no phase, so they hold
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      self_power_enable <= 1'b0;
      carrier_power_enable_out <= 1'b0;
      system_reset_out_n <= 1'b0;
    end else begin
      self_power_enable <= seq != MPS_SEQ_IDLE;
      carrier_power_enable_out <= seq == MPS_SEQ_CARRIER ||
        seq == MPS_SEQ_RUN || seq == MPS_SEQ_RESET;
      system_reset_out_n <= seq == MPS_SEQ_RUN;
    end
  end

endmodule : mps_sequencer

// file: design/mps_pkg.sv
// package: constants and types for the module power state sequencer
package mps_pkg;

  // power states
  typedef enum logic [1:0] {
    MPS_OFF   = 2'b00,
    MPS_ON    = 2'b01,
    MPS_SLEEP = 2'b10
  } mps_state_t;

  // sequencing phases
  typedef enum logic [2:0] {
    MPS_SEQ_IDLE    = 3'b000,
    MPS_SEQ_SELF    = 3'b001,
    MPS_SEQ_CARRIER = 3'b010,
    MPS_SEQ_RUN     = 3'b011,
    MPS_SEQ_RESET   = 3'b100,
    MPS_SEQ_DROP    = 3'b101,
    MPS_SEQ_SELFOFF = 3'b110
  } mps_seq_t;

  // wake index space
  localparam int MPS_WAKE_W = 128;
  localparam int MPS_WAKE_PCIE = 1;
  localparam int MPS_WAKE_BT = 8;
  localparam int MPS_WAKE_WIFI = 9;
  localparam int MPS_WAKE_PWRBTN = 29;
  localparam int MPS_WAKE_USB_VBUS = 53;
  localparam int MPS_WAKE_BATTERY_LOW_IN_N = 56;
  localparam int MPS_WAKE_RECOVERY = 67;
  localparam int MPS_WAKE_SLEEP = 68;
  // internal wake sources (own indices above the connector range)
  localparam int MPS_WAKE_RTC = 100;
  localparam int MPS_WAKE_THERMAL = 101;
  localparam int MPS_WAKE_LOW_VIN = 102;
  localparam int MPS_WAKE_SD_CD = 103;

  // timing
  localparam int MPS_CLK_MHZ = 125;
  localparam int MPS_BTN_HOLD_S = 7;
  localparam longint MPS_BTN_HOLD_CYC =
    longint'(MPS_BTN_HOLD_S) * 64'd1000000 * longint'(MPS_CLK_MHZ);
  localparam int MPS_STEP_NS = 1000;
  localparam int MPS_STEP_CYC = (MPS_STEP_NS * MPS_CLK_MHZ) / 1000;

  // register byte offsets
  localparam logic [11:0] MPS_REG_CTRL = 12'h000;
  localparam logic [11:0] MPS_REG_STATUS = 12'h004;
  localparam logic [11:0] MPS_REG_TIMER = 12'h008;
  localparam logic [11:0] MPS_REG_WAKE_EN0 = 12'h010;
  localparam logic [11:0] MPS_REG_WAKE_ST0 = 12'h020;

  // control register bits (write 1 to act on bits 0 and 1; bits 2 and 3 are levels)
  localparam int MPS_CTRL_SHUTDOWN = 0;
  localparam int MPS_CTRL_SLEEP = 1;
  localparam int MPS_CTRL_SW_UP = 2;
  localparam int MPS_CTRL_CHG_ON = 3;

  localparam logic [31:0] MPS_ZERO = 32'h0000_0000;

  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mps_apb_req_t;

  // environment indications
  typedef struct packed {
    logic thermal_unsafe;
    logic brown_out;
    logic temp_hot;
    logic temp_cold;
    logic low_vin;
  } mps_env_t;

endpackage : mps_pkg

// file: test/mps_carrier_model.sv
// carrier board model: input rail monitor and supplies
`timescale 1ns/10ps
module mps_carrier_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // from module
  input wire logic carrier_power_enable_out,
  input wire logic self_power_enable,
  // bench control
  input wire logic vin_present,
  // to module
  output logic input_power_bad_n,
  output logic self_power_good,
  output logic carrier_rails_on
);
  logic [4:0] vin_cnt;
  logic [3:0] self_cnt;
  ////////////////////////////////////////////////////////////
  // power bad held low until the rail has settled
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset || !vin_present) vin_cnt <= 5'h00;
    else if (vin_cnt != 5'h1f) vin_cnt <= vin_cnt + 5'h01;
  end
  assign input_power_bad_n = (vin_cnt == 5'h1f);
  // own rails ramp slowly, drop at once
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset || !self_power_enable) self_cnt <= 4'h0;
    else if (self_cnt != 4'hf) self_cnt <= self_cnt + 4'h1;
  end
  assign self_power_good = (self_cnt == 4'hf);
  // supplies follow the enable and nothing else
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) carrier_rails_on <= 1'b0;
    else carrier_rails_on <= carrier_power_enable_out;
  end
endmodule : mps_carrier_model

// file: test/mps_sequencer_properties.sv
// checker: sequencing order and power state properties
`timescale 1ns/10ps
module mps_sequencer_checker
  import mps_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // pins
  input wire logic input_power_bad_n,
  input wire logic carrier_power_enable_out,
  input wire logic system_reset_out_n,
  input wire logic self_power_good,
  input wire logic self_power_enable,
  // status and environment
  input wire mps_env_t env,
  input wire mps_state_t power_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_enter(mps_state_t s);
    power_state == s && $past(power_state) != s;
  endsequence
  sequence s_wake;
    $past(power_state) == MPS_SLEEP && power_state == MPS_ON;
  endsequence
  ////////////////////////////////////////////////////////////
  a_carrier_late: assert property ($rose(carrier_power_enable_out)
    |-> self_power_enable && self_power_good)
    else $error("carrier enabled before own rails");
  a_boot_after: assert property ($rose(system_reset_out_n)
    |-> $past(carrier_power_enable_out, 8))
    else $error("reset released too early");
  a_reset_first: assert property ($fell(system_reset_out_n)
    |-> carrier_power_enable_out [*8])
    else $error("carrier dropped with reset");
  a_drop_after: assert property ($fell(carrier_power_enable_out)
    |-> !$past(system_reset_out_n, 8))
    else $error("carrier dropped before reset");
  a_self_last: assert property ($fell(self_power_enable)
    |-> !carrier_power_enable_out && !$past(carrier_power_enable_out, 8))
    else $error("own rails dropped too early");
  a_three_states: assert property (
    power_state inside {MPS_OFF, MPS_ON, MPS_SLEEP})
    else $error("illegal power state");
  a_up_vin_good: assert property ($rose(self_power_enable)
    |-> $past(input_power_bad_n))
    else $error("power up with input bad");
  a_off_from_on: assert property (s_enter(MPS_OFF)
    |-> $past(power_state) == MPS_ON)
    else $error("off entered not from on");
  a_thermal_off: assert property (
    $rose(env.thermal_unsafe) && power_state == MPS_ON
    |-> ##[1:8] !system_reset_out_n)
    else $error("no thermal shutdown");
  a_brown_off: assert property (
    $rose(env.brown_out) && power_state == MPS_ON
    |-> ##[1:8] !system_reset_out_n)
    else $error("no brown-out shutdown");
  a_sleep_from_on: assert property (s_enter(MPS_SLEEP)
    |-> $past(power_state) == MPS_ON)
    else $error("sleep entered not from on");
  a_sleep_holds: assert property (
    power_state == MPS_SLEEP && $past(power_state) == MPS_SLEEP &&
    !$past(env.thermal_unsafe) && !$past(env.brown_out)
    |-> $stable(carrier_power_enable_out) && $stable(system_reset_out_n)
    && $stable(self_power_enable))
    else $error("output moved in sleep");
  a_wake_no_boot: assert property (s_wake
    |-> system_reset_out_n && carrier_power_enable_out)
    else $error("wake went through reboot");
  a_sleep_forced: assert property (
    $rose(env.thermal_unsafe) && power_state == MPS_SLEEP
    |-> ##[1:8] !system_reset_out_n)
    else $error("no thermal shutdown from sleep");
endmodule : mps_sequencer_checker

bind mps_sequencer mps_sequencer_checker u_chk (.sys_clk(sys_clk),
  .reset(reset), .input_power_bad_n(input_power_bad_n),
  .carrier_power_enable_out(carrier_power_enable_out),
  .system_reset_out_n(system_reset_out_n),
  .self_power_good(self_power_good), .self_power_enable(self_power_enable),
  .env(env), .power_state(power_state));

// file: test/mps_sequencer_tb_top.sv
// testbench: power sequencing, states and wake sources
`timescale 1ns/10ps
module mps_sequencer_tb_top;
  import mps_pkg::*;
  logic sys_clk, reset, btn_n, chg_n, rec_n, pcie_n, bat_n, slp_n, usb, sd;
  logic wlan, bt, vin, pready, pslverr, carrier, rst_n, self_en, pbad_n;
  logic self_good, rails, err;
  logic [31:0] prdata, rd;
  mps_apb_req_t req;
  mps_env_t env;
  mps_state_t state;
  int fails, n_checks;
  int wakes[12] = '{1, 8, 9, 29, 53, 56, 67, 68, 100, 101, 102, 103};
  // short button hold keeps the run brief
  mps_sequencer #(.BTN_HOLD_CYC(64'd50)) uut (.sys_clk(sys_clk),
    .reset(reset), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_button_in_n(btn_n), .input_power_bad_n(pbad_n),
    .charger_present_n(chg_n), .recovery_strap_in_n(rec_n),
    .pcie_wake_request_n(pcie_n), .battery_low_in_n(bat_n),
    .sleep_request_n(slp_n), .carrier_power_enable_out(carrier),
    .system_reset_out_n(rst_n), .env(env), .usb_vbus_detect(usb),
    .sd_card_detect(sd), .wlan_wake(wlan), .bt_wake(bt),
    .self_power_good(self_good), .self_power_enable(self_en),
    .power_state(state));
  mps_carrier_model u_carrier (.sys_clk(sys_clk), .reset(reset),
    .carrier_power_enable_out(carrier), .self_power_enable(self_en),
    .vin_present(vin), .input_power_bad_n(pbad_n),
    .self_power_good(self_good), .carrier_rails_on(rails));
  ////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb
  task wst(input mps_state_t s, input int n);
    for (int i = 0; i < n && state !== s; i++) @(posedge sys_clk);
    chk(32'(state), 32'(s));
  endtask : wst
  task pins(input logic [31:0] e);
    chk({29'h0, carrier, rst_n, self_en}, e);
  endtask : pins
  task press(input int n);
    btn_n <= 1'b0;
    cyc(n);
    btn_n <= 1'b1;
  endtask : press
  task up;
    press(4);
    wst(MPS_ON, 1000);
    cyc(1);
    pins(32'h7);
    apb(1'b0, MPS_REG_STATUS, MPS_ZERO);
    chk(rd & 32'h303, 32'h301);
  endtask : up
  task src(input int idx, input logic on);
    case (idx)
      1: pcie_n <= !on;
      8: bt <= on;
      9: wlan <= on;
      29: btn_n <= !on;
      53: usb <= on;
      56: bat_n <= !on;
      67: rec_n <= !on;
      68: slp_n <= !on;
      // expiry falls after the disabled-source check
      100: apb(1'b1, MPS_REG_TIMER, on ? 32'h28 : MPS_ZERO);
      101: env.temp_hot <= on;
      102: env.low_vin <= on;
      default: sd <= on;
    endcase
  endtask : src
  ////////////////////////////////////////////////////////////
  task t_reset;
    pins(MPS_ZERO);
    apb(1'b1, 12'h100, 32'h1);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, MPS_REG_STATUS, MPS_ZERO);
    chk(rd & 32'h3, 32'(MPS_OFF));
    $display("test reset done");
  endtask : t_reset
  task t_refuse;
    press(4);
    apb(1'b1, MPS_REG_CTRL, 32'h2);
    cyc(300);
    chk(32'(state), 32'(MPS_OFF));
    vin <= 1'b1;
    cyc(40);
    $display("test refuse done");
  endtask : t_refuse
  task t_sw_off;
    apb(1'b1, MPS_REG_CTRL, 32'h1);
    cyc(50);
    chk(32'(state), 32'(MPS_ON));
    apb(1'b1, MPS_REG_CTRL, 32'h4);
    apb(1'b1, MPS_REG_CTRL, 32'h5);
    for (int i = 0; i < 50 && rst_n; i++) @(posedge sys_clk);
    chk({30'h0, carrier, rst_n}, 32'h2);
    wst(MPS_OFF, 1000);
    cyc(1);
    chk({30'h0, rails, self_en}, MPS_ZERO);
    $display("test sw shutdown done");
  endtask : t_sw_off
  task t_wake(input int idx);
    int o;
    o = (idx == 1) ? 53 : 1;
    for (int w = 0; w < 4; w++) begin
      apb(1'b1, MPS_REG_WAKE_EN0 + 12'(4 * w),
        (idx / 32 == w) ? 32'h1 << (idx % 32) : MPS_ZERO);
      apb(1'b1, MPS_REG_WAKE_ST0 + 12'(4 * w), 32'hffff_ffff);
    end
    if (idx == 100) src(idx, 1'b1);
    apb(1'b1, MPS_REG_CTRL, 32'h2);
    wst(MPS_SLEEP, 4);
    src(o, 1'b1);
    cyc(20);
    chk(32'(state), 32'(MPS_SLEEP));
    pins(32'h7);
    src(o, 1'b0);
    src(idx, 1'b1);
    wst(MPS_ON, 40);
    pins(32'h7);
    apb(1'b0, MPS_REG_WAKE_ST0 + 12'(4 * (idx / 32)), MPS_ZERO);
    chk(rd, 32'h1 << (idx % 32));
    src(idx, 1'b0);
    $display("test wake %0d done", idx);
  endtask : t_wake
  task t_hold;
    press(20);
    cyc(10);
    chk(32'(state), 32'(MPS_ON));
    press(60);
    wst(MPS_OFF, 1000);
    $display("test button hold done");
  endtask : t_hold
  task t_forced;
    chg_n <= 1'b0;
    cyc(200);
    chk(32'(state), 32'(MPS_OFF));
    apb(1'b1, MPS_REG_CTRL, 32'h8);
    wst(MPS_ON, 1000);
    chg_n <= 1'b1;
    env.thermal_unsafe <= 1'b1;
    wst(MPS_OFF, 1000);
    env.thermal_unsafe <= 1'b0;
    up;
    env.brown_out <= 1'b1;
    wst(MPS_OFF, 1000);
    env.brown_out <= 1'b0;
    up;
    apb(1'b1, MPS_REG_CTRL, 32'h2);
    wst(MPS_SLEEP, 4);
    env.thermal_unsafe <= 1'b1;
    wst(MPS_OFF, 1000);
    env.thermal_unsafe <= 1'b0;
    cyc(1);
    pins(MPS_ZERO);
    $display("test forced shutdown done");
  endtask : t_forced
  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    fails++;
    results;
  end
  initial begin
    {reset, btn_n, chg_n, rec_n, pcie_n, bat_n, slp_n} = 7'h7f;
    {usb, sd, wlan, bt, vin} = 5'h00;
    req = '0;
    env = '0;
    fails = 0;
    n_checks = 0;
    cyc(16);
    reset <= 1'b0;
    t_reset;
    t_refuse;
    up;
    t_sw_off;
    up;
    foreach (wakes[i]) t_wake(wakes[i]);
    t_hold;
    t_forced;
    results;
  end
endmodule : mps_sequencer_tb_top
